// >>> msw_pkg.sv
// What this block does
// - Mode codes select normal, sleep, stop, soft reset
// - Third regulator enable bit switches it on
// - Second regulator field selects its on-modes
// - Overvoltage always flags; restart only if enabled
// - Threshold code 00 highest, higher codes lower
// - Stop to sleep command is refused
// - Restart rewrites mode field to normal
// - Restart or overtemperature turns second regulator off
// - Write returns the previously programmed value
// - Voltage bit selects main or fixed voltage
// - Mask bit decides reset pin during soft reset
// - Activation bit drives failure outputs by software
// - Clearing activation bit keeps failure-driven outputs
// - Restart clears activation bit, releases failure outputs
// - Undervoltage disables third regulator unless kept on
// - Load-sharing bit selects stand-alone or shared operation
// - Stop-mode share bit gates load sharing in stop
// - Config bit picks first or second watchdog failure
// - Soft reset keeps voltage and load-sharing bits
// - Watchdog control byte must have even parity
// - Stop disable bit turns watchdog off in stop
// - Window select and bus-wake watchdog start
// - Command is 16 bits: address, mode, data
// - Access bit set writes, clear only reads
// - Reserved bits read as zero
package msw_pkg;
  localparam logic [6:0] ADDR_MODE_SUPPLY = 7'h01;
  localparam logic [6:0] ADDR_HW_SUPPLY = 7'h02;
  localparam logic [6:0] ADDR_WATCHDOG = 7'h03;
  localparam logic [7:0] RST_MODE_SUPPLY = 8'h00;
  localparam logic [7:0] RST_HW_SUPPLY = 8'h00;
  localparam logic [7:0] RST_WATCHDOG = 8'h14;
  // Bits kept over a soft reset, and over a restart
  localparam logic [7:0] SRST_KEEP_HW = 8'h88;
  localparam logic [7:0] RESTART_KEEP_MS = 8'h23;
  localparam logic [7:0] RESTART_KEEP_HW = 8'hD9;
  localparam logic [7:0] RESTART_KEEP_WD = 8'hB0;
  localparam logic [7:0] RESTART_VAL_WD = 8'h04;
  localparam logic [7:0] RSV_MASK_HW = 8'hFB;
  localparam logic [7:0] RSV_MASK_WD = 8'hF7;
  localparam int MODE_MSB = 7;
  localparam int MODE_LSB = 6;
  localparam int AUX_EN_BIT = 5;
  localparam int SEC_MSB = 4;
  localparam int SEC_LSB = 3;
  localparam int OV_RST_BIT = 2;
  localparam int AUX_VSEL_BIT = 7;
  localparam int SRST_MASK_BIT = 6;
  localparam int FO_SW_BIT = 5;
  localparam int AUX_UVKEEP_BIT = 4;
  localparam int AUX_LS_BIT = 3;
  localparam int AUX_LS_STOP_BIT = 1;
  localparam int CFG_BIT = 0;
  localparam int WD_STOP_BIT = 6;
  localparam int WATCHDOG_WINDOW_SELECT_BIT = 5;
  localparam int WD_BUSWK_BIT = 4;
  localparam int CMD_WR_BIT = 7;
  localparam int CMD_DATA_LSB = 8;
  localparam int CLK_PERIOD_NS = 25;
  localparam int SRST_TIME_NS = 2000;
  localparam int SRST_CYCLES = (SRST_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  typedef enum logic [1:0] {MODE_NORMAL, MODE_SLEEP, MODE_STOP, MODE_SOFT_RST} msw_mode_t;
  typedef enum logic [1:0] {SEC_OFF, SEC_NORMAL, SEC_NORMAL_STOP, SEC_ALWAYS} msw_sec_t;
endpackage

// >>> msw_cmd_if.sv
`timescale 1ns/1ps
`default_nettype none
interface msw_cmd_if;
  logic valid;
  logic write;
  logic [6:0] addr;
  logic [7:0] wdata;
  modport source (output valid, output write, output addr, output wdata);
  modport sink (input valid, input write, input addr, input wdata);
endinterface
`default_nettype wire

// >>> msw_cmd_decode.sv
`timescale 1ns/1ps
`default_nettype none
module msw_cmd_decode
  import msw_pkg::*;
(
  // Command word
  input wire logic cmd_valid,
  input wire logic [15:0] cmd_word,
  // Decoded command
  msw_cmd_if.source cmd
);
  assign cmd.valid = cmd_valid;
  assign cmd.addr = cmd_word[6:0];
  assign cmd.write = cmd_word[CMD_WR_BIT];
  assign cmd.wdata = cmd_word[CMD_DATA_LSB +: 8];
endmodule
`default_nettype wire

// >>> msw_parity_chk.sv
`timescale 1ns/1ps
`default_nettype none
module msw_parity_chk
#(
  parameter int WIDTH = 8
)
(
  // Byte under test
  input wire logic [WIDTH-1:0] data,
  // Result
  output logic even_ok
);
  if (WIDTH < 1)
  begin : g_chk
    $error("parity width must be positive");
  end
  assign even_ok = ~(^data);
endmodule
`default_nettype wire

// >>> msw_ctrl_regs.sv
`timescale 1ns/1ps
`default_nettype none
module msw_ctrl_regs
  import msw_pkg::*;
#(
  parameter int SRST_LEN = SRST_CYCLES
)
(
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // Command port, one 16-bit frame per valid cycle
  input wire logic cmd_valid,
  input wire logic [15:0] cmd_word,
  output logic rsp_valid,
  output logic [7:0] rsp_data,
  output logic cmd_refused,
  // Chip events
  input wire logic restart_enter,
  input wire logic overtemp_event,
  input wire logic main_overvolt_event,
  input wire logic supply_undervoltage,
  input wire logic failure_active,
  input wire logic fail_safe_mode,
  input wire logic high_power_mode,
  // Mode and reset
  output logic [1:0] operating_mode,
  output logic soft_reset_active,
  output logic reset_output_pin_low,
  // Regulators
  output logic aux_reg_enable,
  output logic aux_reg_on,
  output logic aux_voltage_select,
  output logic aux_load_share_active,
  output logic second_reg_on,
  output logic [1:0] main_reset_threshold,
  output logic main_overvolt_flag,
  output logic main_overvolt_restart_req,
  // Failure outputs and watchdog setup
  output logic failure_outputs,
  output logic restart_cfg_select,
  output logic watchdog_stop_disable_lo,
  output logic watchdog_window_select,
  output logic watchdog_bus_wake_start,
  output logic [2:0] watchdog_period_select,
  output logic watchdog_parity_error
);
  if (SRST_LEN < 1)
  begin : g_len_chk
    $error("soft reset length must be at least one cycle");
  end

  localparam int CW = $clog2(SRST_LEN + 1);
  localparam logic [CW-1:0] SRST_LAST = CW'(SRST_LEN - 1);

  function automatic logic hit(input logic [6:0] a, input logic [6:0] target);
    return a == target;
  endfunction

  msw_cmd_if cmd ();

  msw_cmd_decode u_dec (
    .cmd_valid(cmd_valid),
    .cmd_word(cmd_word),
    .cmd(cmd)
  );

  logic [7:0] ms_q;
  logic [7:0] hw_q;
  logic [7:0] wd_q;
  logic srst_busy_q;
  logic [CW-1:0] srst_cnt_q;
  logic rsp_valid_q;
  logic [7:0] rsp_data_q;
  logic refused_q;
  logic ov_flag_q;
  logic ov_req_q;
  logic par_err_q;
  logic wd_even;

  msw_parity_chk #(.WIDTH(8)) u_par (
    .data(cmd.wdata),
    .even_ok(wd_even)
  );

  logic wr;
  logic stop_to_sleep;
  logic wr_ms;
  logic wr_hw;
  logic wr_wd;
  logic srst_start;
  logic srst_done;
  logic in_stop;

  assign wr = cmd.valid & cmd.write & ~srst_busy_q;
  // Stop may leave towards normal or soft reset, not sleep; sleep is reached from normal or sleep only
  assign stop_to_sleep = ms_q[MODE_MSB:MODE_LSB] == MODE_STOP
    && cmd.wdata[MODE_MSB:MODE_LSB] == MODE_SLEEP;
  assign wr_ms = wr & hit(cmd.addr, ADDR_MODE_SUPPLY) & ~stop_to_sleep;
  assign wr_hw = wr & hit(cmd.addr, ADDR_HW_SUPPLY);
  assign wr_wd = wr & hit(cmd.addr, ADDR_WATCHDOG);
  assign srst_start = wr_ms && cmd.wdata[MODE_MSB:MODE_LSB] == MODE_SOFT_RST;
  assign srst_done = srst_busy_q && srst_cnt_q == SRST_LAST;
  assign in_stop = ms_q[MODE_MSB:MODE_LSB] == MODE_STOP;

  // Soft reset sequencer
  // Writes are refused while it runs, so a second soft reset cannot restart the count
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      srst_busy_q <= 1'b0;
      srst_cnt_q <= '0;
    end
    else if (srst_start)
    begin
      srst_busy_q <= 1'b1;
      srst_cnt_q <= '0;
    end
    else if (srst_done)
    begin
      srst_busy_q <= 1'b0;
      srst_cnt_q <= '0;
    end
    else if (srst_busy_q)
    begin
      srst_cnt_q <= srst_cnt_q + CW'(1);
    end
  end

  // Mode and supply register; hardware changes win over a same-cycle write
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      ms_q <= RST_MODE_SUPPLY;
    end
    else if (srst_done)
    begin
      ms_q <= RST_MODE_SUPPLY;
    end
    else
    begin
      if (wr_ms)
      begin
        ms_q <= cmd.wdata;
      end
      if (restart_enter)
      begin
        // Mode back to normal, second regulator and overvoltage restart off
        ms_q <= (wr_ms ? cmd.wdata : ms_q) & RESTART_KEEP_MS;
      end
      else if (overtemp_event)
      begin
        ms_q[SEC_MSB:SEC_LSB] <= SEC_OFF;
        if (wr_ms)
        begin
          ms_q[7:5] <= cmd.wdata[7:5];
          ms_q[2:0] <= cmd.wdata[2:0];
        end
      end
    end
  end

  // Hardware supply configuration
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      hw_q <= RST_HW_SUPPLY;
    end
    else if (srst_done)
    begin
      hw_q <= hw_q & SRST_KEEP_HW;
    end
    else if (restart_enter)
    begin
      // Clears the software failure activation among others
      hw_q <= (wr_hw ? (cmd.wdata & RSV_MASK_HW) : hw_q) & RESTART_KEEP_HW;
    end
    else if (wr_hw)
    begin
      hw_q <= cmd.wdata & RSV_MASK_HW;
    end
  end

  // Watchdog control; stored even with bad parity so the watchdog can react
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      wd_q <= RST_WATCHDOG;
    end
    else if (srst_done)
    begin
      wd_q <= RST_WATCHDOG;
    end
    else if (restart_enter)
    begin
      wd_q <= ((wr_wd ? (cmd.wdata & RSV_MASK_WD) : wd_q) & RESTART_KEEP_WD)
        | RESTART_VAL_WD;
    end
    else if (wr_wd)
    begin
      wd_q <= cmd.wdata & RSV_MASK_WD;
    end
  end

  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      par_err_q <= 1'b0;
    end
    else
    begin
      par_err_q <= wr_wd & ~wd_even;
    end
  end

  // Every command is answered, reads and refused writes alike
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      rsp_valid_q <= 1'b0;
    end
    else
    begin
      rsp_valid_q <= cmd.valid;
    end
  end

  // Answer always shows the content before this command's write
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      rsp_data_q <= 8'h00;
    end
    else
    begin
      if (cmd.valid)
      begin
        if (hit(cmd.addr, ADDR_MODE_SUPPLY))
        begin
          rsp_data_q <= ms_q;
        end
        else if (hit(cmd.addr, ADDR_HW_SUPPLY))
        begin
          rsp_data_q <= hw_q & RSV_MASK_HW;
        end
        else if (hit(cmd.addr, ADDR_WATCHDOG))
        begin
          rsp_data_q <= wd_q & RSV_MASK_WD;
        end
        else
        begin
          rsp_data_q <= 8'h00;
        end
      end
    end
  end

  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      refused_q <= 1'b0;
    end
    else
    begin
      refused_q <= cmd.valid & cmd.write & (srst_busy_q
        | (hit(cmd.addr, ADDR_MODE_SUPPLY) & stop_to_sleep));
    end
  end

  // Overvoltage: flag always, restart request only when enabled
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      ov_flag_q <= 1'b0;
    end
    else
    begin
      ov_flag_q <= main_overvolt_event;
    end
  end

  // Request uses the enable as it stood before any same-cycle write
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      ov_req_q <= 1'b0;
    end
    else
    begin
      ov_req_q <= main_overvolt_event & ms_q[OV_RST_BIT];
    end
  end

  assign rsp_valid = rsp_valid_q;
  assign rsp_data = rsp_data_q;
  assign cmd_refused = refused_q;
  assign main_overvolt_flag = ov_flag_q;
  assign main_overvolt_restart_req = ov_req_q;
  assign watchdog_parity_error = par_err_q;

  assign operating_mode = ms_q[MODE_MSB:MODE_LSB];
  assign soft_reset_active = srst_busy_q;
  assign reset_output_pin_low = srst_busy_q & ~hw_q[SRST_MASK_BIT];
  assign main_reset_threshold = ms_q[1:0];

  // Third regulator
  assign aux_reg_enable = ms_q[AUX_EN_BIT];
  assign aux_reg_on = ms_q[AUX_EN_BIT]
    & ~(supply_undervoltage & ~hw_q[AUX_UVKEEP_BIT]);
  assign aux_voltage_select = hw_q[AUX_VSEL_BIT];
  // Sharing is dropped in stop and high power unless allowed there
  assign aux_load_share_active = hw_q[AUX_LS_BIT]
    & (~(in_stop | high_power_mode) | hw_q[AUX_LS_STOP_BIT]);

  // Second regulator
  always_comb
  begin
    unique case (msw_sec_t'(ms_q[SEC_MSB:SEC_LSB]))
      SEC_OFF: second_reg_on = 1'b0;
      SEC_NORMAL: second_reg_on = operating_mode == MODE_NORMAL;
      SEC_NORMAL_STOP: second_reg_on = operating_mode == MODE_NORMAL || in_stop;
      SEC_ALWAYS: second_reg_on = ~fail_safe_mode;
    endcase
  end

  // Failure-driven activation holds until the failure status is cleared
  assign failure_outputs = hw_q[FO_SW_BIT] | failure_active;
  assign restart_cfg_select = hw_q[CFG_BIT];

  assign watchdog_stop_disable_lo = wd_q[WD_STOP_BIT];
  assign watchdog_window_select = wd_q[WATCHDOG_WINDOW_SELECT_BIT];
  assign watchdog_bus_wake_start = wd_q[WD_BUSWK_BIT];
  assign watchdog_period_select = wd_q[2:0];
endmodule
`default_nettype wire

// >>> msw_ctrl_regs_chk.sv
`timescale 1ns/1ps
`default_nettype none
module msw_ctrl_regs_chk
#(
  parameter int SRST_LEN = 80
)
(
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // Command port
  input wire logic cmd_valid,
  input wire logic [15:0] cmd_word,
  input wire logic rsp_valid,
  input wire logic cmd_refused,
  // Chip events
  input wire logic restart_enter,
  input wire logic overtemp_event,
  input wire logic main_overvolt_event,
  input wire logic failure_active,
  // Observed state
  input wire logic [1:0] operating_mode,
  input wire logic soft_reset_active,
  input wire logic second_reg_on,
  input wire logic main_overvolt_flag,
  input wire logic [1:0] main_reset_threshold,
  input wire logic failure_outputs,
  input wire logic watchdog_parity_error
);
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  int srst_cnt_q;
  always_ff @(posedge mclk or posedge sys_rst)
    if (sys_rst)
      srst_cnt_q <= 0;
    else
      srst_cnt_q <= soft_reset_active ? srst_cnt_q + 1 : 0;
  // Write to the mode register outside soft reset, stop to sleep included; restart would override it
  sequence s_ms_wr;
    cmd_valid && cmd_word[7] && cmd_word[6:0] == 7'h01 && !soft_reset_active && !restart_enter;
  endsequence
  chk_rsp_next:
    assert property (cmd_valid |=> rsp_valid) else $error("command not answered");
  chk_mode_write:
    assert property (s_ms_wr ##0 !cmd_word[14] |=> operating_mode == $past(cmd_word[15:14])
      && main_reset_threshold == $past(cmd_word[9:8])) else $error("mode write lost");
  chk_stop_sleep:
    assert property (s_ms_wr ##0 (cmd_word[15:14] == 2'b01 && operating_mode == 2'b10)
      |=> cmd_refused && operating_mode == 2'b10) else $error("stop to sleep taken");
  chk_soft_start:
    assert property (s_ms_wr ##0 cmd_word[15:14] == 2'b11 |=> soft_reset_active
      && operating_mode == 2'b11) else $error("soft reset not started");
  chk_srst_length:
    assert property (soft_reset_active |-> srst_cnt_q <= SRST_LEN) else $error("soft reset long");
  chk_srst_done:
    assert property ($fell(soft_reset_active) |-> operating_mode == 2'b00) else $error("mode kept");
  chk_restart_mode:
    assert property (restart_enter |=> operating_mode == 2'b00 && !second_reg_on)
      else $error("restart values wrong");
  chk_overtemp_sec:
    assert property (overtemp_event |=> !second_reg_on) else $error("second regulator on");
  chk_ov_flag:
    assert property (main_overvolt_event |=> main_overvolt_flag) else $error("no overvolt flag");
  chk_fo_hold:
    assert property (failure_active |-> failure_outputs) else $error("failure output released");
  chk_restart_fo:
    assert property (restart_enter ##1 !failure_active |-> !failure_outputs)
      else $error("failure output kept");
  chk_parity_flag:
    assert property (cmd_valid && cmd_word[7] && cmd_word[6:0] == 7'h03 && !soft_reset_active
      |=> watchdog_parity_error == $past(^cmd_word[15:8])) else $error("parity flag wrong");
endmodule
bind msw_ctrl_regs msw_ctrl_regs_chk #(.SRST_LEN(SRST_LEN)) u_chk (.mclk, .sys_rst, .cmd_valid,
  .cmd_word, .rsp_valid, .cmd_refused, .restart_enter, .overtemp_event, .main_overvolt_event,
  .failure_active, .operating_mode, .soft_reset_active, .second_reg_on, .main_overvolt_flag,
  .main_reset_threshold, .failure_outputs, .watchdog_parity_error);
`default_nettype wire

// >>> msw_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module msw_host_model
(
  // Clock
  input wire logic mclk,
  // Command frame
  output logic cmd_valid,
  output logic [15:0] cmd_word
);
  initial
  begin
    cmd_valid = 1'b0;
    cmd_word = 16'h0000;
  end
  // Idle word is inverted so stale data never passes for a command
  task automatic send(input logic [6:0] a, input logic w, input logic [7:0] d);
    @(negedge mclk);
    cmd_word = {d, w, a};
    cmd_valid = 1'b1;
    @(negedge mclk);
    cmd_valid = 1'b0;
    cmd_word = ~cmd_word;
  endtask
  function automatic logic [7:0] wd_byte(input logic [6:0] d);
    return {^d, d};
  endfunction
endmodule
`default_nettype wire

// >>> msw_ctrl_regs_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module msw_ctrl_regs_tb_top;
  import msw_pkg::*;
  logic mclk, sys_rst, cmd_valid, rsp_valid, cmd_refused, restart_enter, overtemp_event;
  logic main_overvolt_event, supply_undervoltage, failure_active, fail_safe_mode, high_power_mode;
  logic soft_reset_active, reset_output_pin_low, aux_reg_enable, aux_reg_on, aux_voltage_select;
  logic aux_load_share_active, second_reg_on, main_overvolt_flag, main_overvolt_restart_req;
  logic failure_outputs, restart_cfg_select, watchdog_stop_disable_lo, watchdog_window_select;
  logic watchdog_bus_wake_start, watchdog_parity_error;
  logic [15:0] cmd_word;
  logic [7:0] rsp_data, ms, hw, d, lf;
  logic [1:0] operating_mode, main_reset_threshold;
  logic [2:0] watchdog_period_select;
  logic [7:0] exp_q[$];
  int bad_count, compares;
  msw_ctrl_regs #(.SRST_LEN(4)) dut (
    .mclk(mclk), .sys_rst(sys_rst), .cmd_valid(cmd_valid), .cmd_word(cmd_word),
    .rsp_valid(rsp_valid), .rsp_data(rsp_data), .cmd_refused(cmd_refused),
    .restart_enter(restart_enter), .overtemp_event(overtemp_event),
    .main_overvolt_event(main_overvolt_event), .supply_undervoltage(supply_undervoltage),
    .failure_active(failure_active), .fail_safe_mode(fail_safe_mode),
    .high_power_mode(high_power_mode), .operating_mode(operating_mode),
    .soft_reset_active(soft_reset_active), .reset_output_pin_low(reset_output_pin_low),
    .aux_reg_enable(aux_reg_enable), .aux_reg_on(aux_reg_on),
    .aux_voltage_select(aux_voltage_select), .aux_load_share_active(aux_load_share_active),
    .second_reg_on(second_reg_on), .main_reset_threshold(main_reset_threshold),
    .main_overvolt_flag(main_overvolt_flag),
    .main_overvolt_restart_req(main_overvolt_restart_req),
    .failure_outputs(failure_outputs), .restart_cfg_select(restart_cfg_select),
    .watchdog_stop_disable_lo(watchdog_stop_disable_lo),
    .watchdog_window_select(watchdog_window_select),
    .watchdog_bus_wake_start(watchdog_bus_wake_start),
    .watchdog_period_select(watchdog_period_select),
    .watchdog_parity_error(watchdog_parity_error)
  );
  msw_host_model host (.mclk(mclk), .cmd_valid(cmd_valid), .cmd_word(cmd_word));
  initial
  begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task complete_run;
    $display("compares=%0d bad_count=%0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task acc(input logic [6:0] a, input logic w, input logic [7:0] dd, input logic [7:0] exp);
    exp_q.push_back(exp);
    host.send(a, w, dd);
  endtask
  task pulse(input logic [2:0] e);
    @(negedge mclk);
    {main_overvolt_event, overtemp_event, restart_enter} = e;
    @(negedge mclk);
    {main_overvolt_event, overtemp_event, restart_enter} = 3'b000;
  endtask
  task wait_srst;
    int n;
    for (n = 0; n < 50 && soft_reset_active === 1'b1; n++) @(negedge mclk);
    if (n == 50)
    begin
      bad_count++;
      complete_run;
    end
  endtask
  always @(negedge mclk)
    if (rsp_valid === 1'b1)
      check(rsp_data, exp_q.size() > 0 ? exp_q.pop_front() : 8'hXX);
  initial
  begin
    #500000;
    bad_count++;
    complete_run;
  end
  initial
  begin
    sys_rst = 1'b1;
    {restart_enter, overtemp_event, main_overvolt_event, supply_undervoltage} = 4'h0;
    {failure_active, fail_safe_mode, high_power_mode} = 3'h0;
    bad_count = 0;
    compares = 0;
    lf = 8'h2F;
    hw = 8'h00;
    repeat (16) @(negedge mclk);
    sys_rst = 1'b0;
    acc(7'h01, 1'b0, 8'h00, 8'h00);
    acc(7'h02, 1'b0, 8'h00, 8'h00);
    acc(7'h03, 1'b0, 8'h00, 8'h14);
    acc(7'h7F, 1'b0, 8'h00, 8'h00);
    acc(7'h01, 1'b1, 8'h2B, 8'h00);
    acc(7'h01, 1'b0, 8'h00, 8'h2B);
    check({6'h00, main_reset_threshold}, 8'h03);
    check({7'h00, aux_reg_enable}, 8'h01);
    check({7'h00, second_reg_on}, 8'h01);
    ms = 8'h2B;
    // Stop mode with every second-regulator code; a sleep request must bounce
    for (int c = 0; c < 4; c++)
    begin
      d = {3'b100, c[1:0], 3'b000};
      acc(7'h01, 1'b1, d, ms);
      ms = d;
      check({7'h00, second_reg_on}, {7'h00, c[1]});
      acc(7'h01, 1'b1, 8'h40, ms);
      check({6'h00, cmd_refused, 1'b0}, 8'h02);
      check({6'h00, operating_mode}, 8'h02);
    end
    fail_safe_mode = 1'b1;
    @(negedge mclk);
    check({7'h00, second_reg_on}, 8'h00);
    fail_safe_mode = 1'b0;
    pulse(3'b010);
    check({7'h00, second_reg_on}, 8'h00);
    acc(7'h01, 1'b1, 8'h04, ms & 8'hE7);
    pulse(3'b100);
    check({6'h00, main_overvolt_flag, main_overvolt_restart_req}, 8'h03);
    repeat (4)
    begin
      lf = lfsr(lf);
      d = lf & 8'hFB;
      acc(7'h02, 1'b1, d, hw);
      hw = d;
      check({7'h00, failure_outputs}, {7'h00, hw[5]});
      check({6'h00, aux_voltage_select, restart_cfg_select}, {6'h00, hw[7], hw[0]});
      check({7'h00, aux_load_share_active}, {7'h00, hw[3]});
    end
    acc(7'h02, 1'b0, 8'h00, hw);
    acc(7'h03, 1'b1, 8'hFF, 8'h14);
    check({7'h00, watchdog_parity_error}, 8'h00);
    check({2'h0, watchdog_stop_disable_lo, watchdog_window_select, watchdog_bus_wake_start,
      watchdog_period_select}, 8'h3F);
    acc(7'h03, 1'b1, 8'h7F, 8'hF7);
    check({7'h00, watchdog_parity_error}, 8'h01);
    acc(7'h03, 1'b1, host.wd_byte(7'h15), 8'h77);
    check({7'h00, watchdog_parity_error}, 8'h00);
    acc(7'h02, 1'b1, 8'h20, hw);
    acc(7'h01, 1'b1, 8'hB8, 8'h04);
    pulse(3'b001);
    check({5'h00, failure_outputs, operating_mode}, 8'h00);
    acc(7'h01, 1'b0, 8'h00, 8'h20);
    acc(7'h02, 1'b0, 8'h00, 8'h00);
    acc(7'h03, 1'b0, 8'h00, 8'h94);
    // The B8 mode write before the restart cleared the overvoltage restart enable
    pulse(3'b100);
    check({6'h00, main_overvolt_flag, main_overvolt_restart_req}, 8'h02);
    failure_active = 1'b1;
    @(negedge mclk);
    check({7'h00, failure_outputs}, 8'h01);
    failure_active = 1'b0;
    supply_undervoltage = 1'b1;
    @(negedge mclk);
    check({6'h00, aux_reg_enable, aux_reg_on}, 8'h02);
    supply_undervoltage = 1'b0;
    acc(7'h02, 1'b1, 8'h89, 8'h00);
    check({7'h00, aux_load_share_active}, 8'h01);
    high_power_mode = 1'b1;
    @(negedge mclk);
    check({7'h00, aux_load_share_active}, 8'h00);
    high_power_mode = 1'b0;
    acc(7'h01, 1'b1, 8'hC0, 8'h20);
    check({6'h00, soft_reset_active, reset_output_pin_low}, 8'h03);
    acc(7'h01, 1'b1, 8'h00, 8'hC0);
    check({7'h00, cmd_refused}, 8'h01);
    wait_srst();
    acc(7'h01, 1'b0, 8'h00, 8'h00);
    acc(7'h02, 1'b0, 8'h00, 8'h88);
    acc(7'h03, 1'b0, 8'h00, 8'h14);
    acc(7'h02, 1'b1, 8'hC8, 8'h88);
    acc(7'h01, 1'b1, 8'hC0, 8'h00);
    check({6'h00, soft_reset_active, reset_output_pin_low}, 8'h02);
    wait_srst();
    acc(7'h02, 1'b0, 8'h00, 8'h88);
    // Only a power-on reset clears the kept supply bits
    @(negedge mclk);
    sys_rst = 1'b1;
    repeat (2) @(negedge mclk);
    sys_rst = 1'b0;
    acc(7'h02, 1'b0, 8'h00, 8'h00);
    repeat (3) @(negedge mclk);
    check({7'h00, exp_q.size() == 0}, 8'h01);
    complete_run;
  end
endmodule
`default_nettype wire
